// ===== verilog/tpl_pkg.sv
// Constants, register indices and carrier types for the probe latch.
// Assumes a 40 MHz drive clock and a 32-bit AXI4-Lite register bus.
package tpl_pkg;

	// ==========================================================
	// Timing
	localparam int TPL_CLK_NS = 25;
	localparam int TPL_FILT_STEP_NS = 10;
	localparam logic [9:0] TPL_FILT_MAX = 10'h3e8;
	localparam int TPL_FILT_CNT_W = 9;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [15:0] TPL_IDX_CTRL = 16'h60b8;
	localparam logic [15:0] TPL_IDX_STATUS = 16'h60b9;
	localparam logic [15:0] TPL_IDX_ONE_RISE = 16'h60ba;
	localparam logic [15:0] TPL_IDX_ONE_FALL = 16'h60bb;
	localparam logic [15:0] TPL_IDX_TWO_RISE = 16'h60bc;
	localparam logic [15:0] TPL_IDX_TWO_FALL = 16'h60bd;
	localparam logic [15:0] TPL_IDX_PIN_SEL = 16'h0331;
	localparam logic [15:0] TPL_IDX_FILT = 16'h0332;
	localparam logic [15:0] TPL_IDX_POL = 16'h0333;
	localparam logic [15:0] TPL_IDX_RESTART = 16'h0334;

	// ==========================================================
	// Control byte layout, one byte per channel
	localparam int TPL_CTL_EN = 0;
	localparam int TPL_CTL_CONT = 1;
	localparam int TPL_CTL_SRC = 2;
	localparam int TPL_CTL_RISE = 4;
	localparam int TPL_CTL_FALL = 5;
	localparam int TPL_CH_W = 8;

	// ==========================================================
	// Reset values and encodings
	localparam logic [1:0] TPL_PIN_ONE_RST = 2'h0;
	localparam logic [1:0] TPL_PIN_TWO_RST = 2'h1;
	localparam logic [1:0] TPL_PIN_MAX = 2'h2;
	localparam int TPL_NUM_PINS = 3;
	localparam logic [1:0] TPL_RESP_OKAY = 2'h0;
	localparam logic [1:0] TPL_RESP_SLVERR = 2'h2;

	// ==========================================================
	// Bus carriers
	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic [2:0] awprot;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic [2:0] arprot;
		logic rready;
	} tpl_axi_m2s_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tpl_axi_s2m_t;

	// Per-channel capture state
	typedef struct packed {
		logic prev;
		logic rise_held;
		logic fall_held;
		logic [1:0] count;
		logic [31:0] rise_pos;
		logic [31:0] fall_pos;
	} tpl_chan_t;

	// Filter time in steps to whole clock cycles, rounded up
	function automatic logic [TPL_FILT_CNT_W-1:0] tpl_filt_cycles(input logic [9:0] t);
		logic [15:0] ns;
		ns = 16'(t) * 16'(TPL_FILT_STEP_NS);
		return TPL_FILT_CNT_W'((ns + 16'(TPL_CLK_NS) - 16'h1) / 16'(TPL_CLK_NS));
	endfunction : tpl_filt_cycles

endpackage : tpl_pkg

// ===== verilog/tpl_filter.sv
// Input synchroniser and digital filter for one probe pin.
// Assumes the pin is asynchronous to aclk; limit comes from aclk logic.
`timescale 1ns/1ps
module tpl_filter (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin and filter length
	input wire logic pin,
	input wire logic [tpl_pkg::TPL_FILT_CNT_W-1:0] limit,
	// Filtered level
	output logic level
);
	import tpl_pkg::*;

	typedef struct packed {
		logic [2:0] sync;
		logic stable;
		logic out;
		logic [TPL_FILT_CNT_W-1:0] cnt;
	} tpl_flt_state_t;

	tpl_flt_state_t s;
	tpl_flt_state_t next_s;

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.sync = {s.sync[1:0], pin};
		// A change counts only once stages two and three agree
		if (s.sync[2] == s.sync[1]) begin
			next_s.stable = s.sync[2];
		end
		// Level must hold for the full limit before it passes
		if (s.stable != s.out) begin
			if (s.cnt >= limit) begin
				next_s.out = s.stable;
				next_s.cnt = '0;
			end else begin
				next_s.cnt = s.cnt + TPL_FILT_CNT_W'(1);
			end
		end else begin
			next_s.cnt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.out;

endmodule : tpl_filter

// ===== verilog/tpl_latch.sv
// Two-channel touch-probe position latch with an AXI4-Lite register slave.
// Assumes probe pins and encoder zero pulse are asynchronous; the feedback
// position is produced on aclk.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module tpl_latch (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire tpl_pkg::tpl_axi_m2s_t axi_in,
	output tpl_pkg::tpl_axi_s2m_t axi_out,
	// Probe pins and encoder zero pulse
	input wire logic [tpl_pkg::TPL_NUM_PINS-1:0] probe_pin,
	input wire logic encoder_zero,
	// Feedback position from the position loop
	input wire logic [31:0] feedback_position
);
	import tpl_pkg::*;

	typedef struct packed {
		// Bus slave
		logic awready;
		logic [31:0] awaddr;
		logic wready;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// Configuration
		logic [15:0] ctrl;
		logic [1:0] pin_pend_one;
		logic [1:0] pin_pend_two;
		logic [1:0] pin_one;
		logic [1:0] pin_two;
		logic [1:0] pol_pend;
		logic [1:0] pol;
		logic [9:0] filt_time;
		logic [TPL_FILT_CNT_W-1:0] filt_limit;
		// One quiet cycle after a restart swaps pin or polarity
		logic settle;
		// Capture channels
		tpl_chan_t one;
		tpl_chan_t two;
	} tpl_state_t;

	tpl_state_t s;
	tpl_state_t next_s;

	logic [TPL_NUM_PINS:0] flt_level;
	// Encoder zero rides on top of the pins so each filter has a plain index
	logic [TPL_NUM_PINS:0] flt_pin;

	assign flt_pin = {encoder_zero, probe_pin};

	// ==========================================================
	// Filters: three pins plus the encoder zero pulse
	for (genvar i = 0; i <= TPL_NUM_PINS; i++) begin : g_flt
		tpl_filter u_filter (
			.aclk(aclk),
			.aresetn(aresetn),
			.pin(flt_pin[i]),
			.limit(s.filt_limit),
			.level(flt_level[i])
		);
	end

	// ==========================================================
	// Helpers
	// Byte lanes of a data word; the word index sits above the byte offset
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int ADDR_LSB = 2;

	function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] idx);
		return addr == (32'(idx) << ADDR_LSB);
	endfunction : addr_hit

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < LANES; b++) begin
			if (strb[b]) begin
				res[b*LANE_W +: LANE_W] = data[b*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction : merge

	// Only pins 0 to 2 exist; a choice of 3 is dropped
	function automatic logic pin_ok(input logic [1:0] p);
		return p <= TPL_PIN_MAX;
	endfunction : pin_ok

	// Trigger level after source choice, and polarity for pin sources
	function automatic logic trig_level(input logic [7:0] ctl, input logic [1:0] pin,
			input logic pol, input logic [TPL_NUM_PINS:0] lv);
		logic raw;
		raw = lv[pin];
		if (ctl[TPL_CTL_SRC]) begin
			return lv[TPL_NUM_PINS];
		end
		return pol ? raw : ~raw;
	endfunction : trig_level

	function automatic tpl_chan_t chan_step(input tpl_chan_t c, input logic [7:0] ctl,
			input logic lvl, input logic [31:0] pos, input logic quiet);
		tpl_chan_t n;
		logic rise;
		logic fall;
		logic cont;
		logic take_rise;
		logic take_fall;
		n = c;
		rise = lvl & ~c.prev;
		fall = ~lvl & c.prev;
		cont = ctl[TPL_CTL_CONT];
		// A level jump from a restart swap is not a probe event
		take_rise = rise && ctl[TPL_CTL_RISE] && !quiet;
		take_fall = fall && ctl[TPL_CTL_FALL] && !quiet;
		n.prev = lvl;
		if (!ctl[TPL_CTL_EN]) begin
			// Disable clears the flags so a re-enable arms single mode again
			n.rise_held = 1'b0;
			n.fall_held = 1'b0;
			n.count = 2'h0;
		end else begin
			if (take_rise && (cont || !c.rise_held)) begin
				n.rise_pos = pos;
				n.rise_held = 1'b1;
			end
			if (take_fall && (cont || !c.fall_held)) begin
				n.fall_pos = pos;
				n.fall_held = 1'b1;
			end
			// Counter wraps 3 to 0 by its width
			if (cont && (take_rise || take_fall)) begin
				n.count = c.count + 2'h1;
			end
		end
		return n;
	endfunction : chan_step

	function automatic logic [7:0] status_byte(input tpl_chan_t c, input logic en);
		// Bits 3 to 5 stay zero
		return {c.count, 3'h0, c.fall_held, c.rise_held, en};
	endfunction : status_byte

	function automatic logic [15:0] status_word(input tpl_state_t st);
		logic [15:0] w;
		w[7:0] = status_byte(st.one, st.ctrl[TPL_CTL_EN]);
		w[15:8] = status_byte(st.two, st.ctrl[TPL_CH_W + TPL_CTL_EN]);
		return w;
	endfunction : status_word

	// Writes to read-only objects answer OKAY and change nothing
	function automatic logic known_addr(input logic [31:0] a);
		return addr_hit(a, TPL_IDX_CTRL) || addr_hit(a, TPL_IDX_STATUS) ||
			addr_hit(a, TPL_IDX_ONE_RISE) || addr_hit(a, TPL_IDX_ONE_FALL) ||
			addr_hit(a, TPL_IDX_TWO_RISE) || addr_hit(a, TPL_IDX_TWO_FALL) ||
			addr_hit(a, TPL_IDX_PIN_SEL) || addr_hit(a, TPL_IDX_FILT) ||
			addr_hit(a, TPL_IDX_POL) || addr_hit(a, TPL_IDX_RESTART);
	endfunction : known_addr

	function automatic logic [31:0] read_data(input tpl_state_t st, input logic [31:0] a);
		logic [31:0] d;
		d = 32'h0;
		if (addr_hit(a, TPL_IDX_CTRL)) begin
			d = {16'h0, st.ctrl};
		end else if (addr_hit(a, TPL_IDX_STATUS)) begin
			d = {16'h0, status_word(st)};
		end else if (addr_hit(a, TPL_IDX_ONE_RISE)) begin
			d = st.one.rise_pos;
		end else if (addr_hit(a, TPL_IDX_ONE_FALL)) begin
			d = st.one.fall_pos;
		end else if (addr_hit(a, TPL_IDX_TWO_RISE)) begin
			d = st.two.rise_pos;
		end else if (addr_hit(a, TPL_IDX_TWO_FALL)) begin
			d = st.two.fall_pos;
		end else if (addr_hit(a, TPL_IDX_PIN_SEL)) begin
			d = {28'h0, st.pin_pend_two, st.pin_pend_one};
		end else if (addr_hit(a, TPL_IDX_FILT)) begin
			d = {22'h0, st.filt_time};
		end else if (addr_hit(a, TPL_IDX_POL)) begin
			d = {30'h0, st.pol_pend};
		end
		return d;
	endfunction : read_data

	// Power-up values: bus ready, default pin choice, everything else clear
	function automatic tpl_state_t reset_state();
		tpl_state_t r;
		r = '0;
		r.awready = 1'b1;
		r.wready = 1'b1;
		r.arready = 1'b1;
		r.pin_pend_one = TPL_PIN_ONE_RST;
		r.pin_pend_two = TPL_PIN_TWO_RST;
		r.pin_one = TPL_PIN_ONE_RST;
		r.pin_two = TPL_PIN_TWO_RST;
		return r;
	endfunction : reset_state

	// ==========================================================
	// Next state
	always_comb begin
		logic [31:0] wv;
		logic lvl_one;
		logic lvl_two;
		wv = 32'h0;
		lvl_one = 1'b0;
		lvl_two = 1'b0;
		next_s = s;
		// Quiet lasts one cycle only
		next_s.settle = 1'b0;

		// Write address and data are taken in either order
		if (axi_in.awvalid && s.awready) begin
			next_s.awaddr = axi_in.awaddr;
			next_s.awready = 1'b0;
		end
		if (axi_in.wvalid && s.wready) begin
			next_s.wdata = axi_in.wdata;
			next_s.wstrb = axi_in.wstrb;
			next_s.wready = 1'b0;
		end

		// Both held: commit and answer
		if (!s.awready && !s.wready && !s.bvalid) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = known_addr(s.awaddr) ? TPL_RESP_OKAY : TPL_RESP_SLVERR;
			if (addr_hit(s.awaddr, TPL_IDX_CTRL)) begin
				wv = merge({16'h0, s.ctrl}, s.wdata, s.wstrb);
				next_s.ctrl = wv[15:0];
			end else if (addr_hit(s.awaddr, TPL_IDX_PIN_SEL)) begin
				wv = merge({28'h0, s.pin_pend_two, s.pin_pend_one}, s.wdata, s.wstrb);
				// Out of range choices are ignored
				if (pin_ok(wv[1:0])) begin
					next_s.pin_pend_one = wv[1:0];
				end
				if (pin_ok(wv[3:2])) begin
					next_s.pin_pend_two = wv[3:2];
				end
			end else if (addr_hit(s.awaddr, TPL_IDX_FILT)) begin
				wv = merge({22'h0, s.filt_time}, s.wdata, s.wstrb);
				if (wv[9:0] <= TPL_FILT_MAX) begin
					next_s.filt_time = wv[9:0];
				end
			end else if (addr_hit(s.awaddr, TPL_IDX_POL)) begin
				wv = merge({30'h0, s.pol_pend}, s.wdata, s.wstrb);
				next_s.pol_pend = wv[1:0];
			end else if (addr_hit(s.awaddr, TPL_IDX_RESTART)) begin
				// Restart loads the pending pin and polarity choices
				if (s.wstrb[0] && s.wdata[0]) begin
					next_s.settle = 1'b1;
					next_s.pin_one = s.pin_pend_one;
					next_s.pin_two = s.pin_pend_two;
					next_s.pol = s.pol_pend;
				end
			end
		end
		if (s.bvalid && axi_in.bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end

		// Read data are sampled when the address is taken
		if (axi_in.arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = read_data(s, axi_in.araddr);
			next_s.rresp = known_addr(axi_in.araddr) ? TPL_RESP_OKAY : TPL_RESP_SLVERR;
		end
		if (s.rvalid && axi_in.rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end

		// Filter length follows the register one cycle later
		next_s.filt_limit = tpl_filt_cycles(s.filt_time);

		// Capture
		lvl_one = trig_level(s.ctrl[TPL_CH_W-1:0], s.pin_one, s.pol[0], flt_level);
		lvl_two = trig_level(s.ctrl[2*TPL_CH_W-1:TPL_CH_W], s.pin_two, s.pol[1],
			flt_level);
		next_s.one = chan_step(s.one, s.ctrl[TPL_CH_W-1:0], lvl_one, feedback_position,
			s.settle);
		next_s.two = chan_step(s.two, s.ctrl[2*TPL_CH_W-1:TPL_CH_W], lvl_two,
			feedback_position, s.settle);
	end

	// ==========================================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= reset_state();
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Bus outputs, all from the state register
	always_comb begin
		axi_out.awready = s.awready;
		axi_out.wready = s.wready;
		axi_out.bvalid = s.bvalid;
		axi_out.bresp = s.bresp;
		axi_out.arready = s.arready;
		axi_out.rvalid = s.rvalid;
		axi_out.rdata = s.rdata;
		axi_out.rresp = s.rresp;
	end

endmodule : tpl_latch

// ===== verif/tpl_latch_asserts.sv
// Bus and status checks for the probe latch, bound to its ports.
// Assumes the master offers address and data of a write together.
`timescale 1ns/1ps
module tpl_asserts (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire tpl_pkg::tpl_axi_m2s_t axi_in,
	input wire tpl_pkg::tpl_axi_s2m_t axi_out,
	// Probe side
	input wire logic [tpl_pkg::TPL_NUM_PINS-1:0] probe_pin,
	input wire logic encoder_zero,
	input wire logic [31:0] feedback_position
);
	import tpl_pkg::*;
	// ==========================================================
	// Shadow of the last read address and of the control word
	logic [31:0] rd_addr;
	logic [15:0] ctrl;
	wire logic st_rd = axi_out.rvalid && rd_addr == {14'h0, TPL_IDX_STATUS, 2'h0};
	wire logic ctl_wr = axi_in.awvalid && axi_out.awready && axi_in.wvalid
		&& axi_out.wready && axi_in.awaddr == {14'h0, TPL_IDX_CTRL, 2'h0};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_addr <= '0;
			ctrl <= '0;
		end else begin
			if (axi_in.arvalid && axi_out.arready)
				rd_addr <= axi_in.araddr;
			if (ctl_wr)
				ctrl <= axi_in.wdata[15:0];
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_R_LAT: assert property (axi_in.arvalid && axi_out.arready |=> axi_out.rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (axi_out.rvalid && !axi_in.rready
		|=> axi_out.rvalid && $stable(axi_out.rdata)) else $error("read data dropped");
	AST_B_HOLD: assert property (axi_out.bvalid && !axi_in.bready
		|=> axi_out.bvalid && $stable(axi_out.bresp)) else $error("write answer dropped");
	AST_RSV: assert property (st_rd |-> axi_out.rdata[5:3] == 3'h0
		&& axi_out.rdata[13:11] == 3'h0) else $error("reserved status bits set");
	AST_EN1: assert property (st_rd |-> axi_out.rdata[0] == ctrl[0])
		else $error("channel one enable bit wrong");
	AST_EN2: assert property (st_rd |-> axi_out.rdata[8] == ctrl[8])
		else $error("channel two enable bit wrong");
	AST_OFF1: assert property (st_rd && !ctrl[0] |-> axi_out.rdata[7:1] == 7'h0)
		else $error("disabled channel keeps flags");
	AST_ONE_CNT: assert property (st_rd && !ctrl[1] |-> axi_out.rdata[7:6] == 2'h0)
		else $error("count moves in single mode");
endmodule : tpl_asserts

bind tpl_latch tpl_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .axi_in(axi_in),
	.axi_out(axi_out), .probe_pin(probe_pin), .encoder_zero(encoder_zero),
	.feedback_position(feedback_position));

// ===== verif/tpl_probe_model.sv
// Probe sensors, encoder zero pulse and feedback position source.
// Assumes pulse is called just after a rising clock edge.
`timescale 1ns/1ps
module tpl_probe_model (
	// Clock
	input wire logic aclk,
	// Probe side
	output logic [2:0] probe_pin,
	output logic encoder_zero,
	output logic [31:0] feedback_position
);
	logic [2:0] idle = 3'h7;
	initial begin
		probe_pin = 3'h7;
		encoder_zero = 1'b0;
		feedback_position = '0;
	end
	// ==========================================================
	// Index 3 is the encoder zero line; position held per edge
	task automatic pulse(input int i, input logic [31:0] a, input logic [31:0] b,
		input int w);
		feedback_position <= a;
		if (i == 3)
			encoder_zero <= 1'b1;
		else
			probe_pin[i] <= ~idle[i];
		repeat (w) @(posedge aclk);
		feedback_position <= b;
		if (i == 3)
			encoder_zero <= 1'b0;
		else
			probe_pin[i] <= idle[i];
		repeat (w) @(posedge aclk);
	endtask : pulse
	task automatic set_idle(input logic [2:0] v);
		idle <= v;
		probe_pin <= v;
	endtask : set_idle
endmodule : tpl_probe_model

// ===== verif/test_touch_probe_position_latch.sv
// Self-checking bench for the probe latch.
// Assumes the partner model drives pins, encoder zero and position.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("mismatch %s exp %h got %h", nm, e, g); \
	end \
end
module test_touch_probe_position_latch;
	import tpl_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	tpl_axi_m2s_t m = '0;
	tpl_axi_s2m_t s;
	wire [2:0] pin;
	wire ezero;
	wire [31:0] fpos;
	int miscompares = 0;
	int checks_done = 0;
	// Edges the master lets an answer stand before taking it
	int lag = 0;
	logic [1:0] last_bresp;
	tpl_latch u_dut (.aclk(aclk), .aresetn(aresetn), .axi_in(m), .axi_out(s),
		.probe_pin(pin), .encoder_zero(ezero), .feedback_position(fpos));
	tpl_probe_model u_pm (.aclk(aclk), .probe_pin(pin), .encoder_zero(ezero),
		.feedback_position(fpos));
	initial forever #12.5 aclk = ~aclk;
	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		@(posedge aclk);
		m.awvalid <= 1'b1;
		m.awaddr <= {14'h0, i, 2'h0};
		m.wvalid <= 1'b1;
		m.wdata <= d;
		m.wstrb <= 4'hf;
		m.bready <= (lag == 0);
		do begin
			@(posedge aclk);
			if (s.awready)
				m.awvalid <= 1'b0;
			if (s.wready)
				m.wvalid <= 1'b0;
		end while (!s.bvalid);
		if (lag > 0) begin
			repeat (lag) @(posedge aclk);
			m.bready <= 1'b1;
			@(posedge aclk);
		end
		last_bresp = s.bresp;
		m.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] i, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		m.arvalid <= 1'b1;
		m.araddr <= {14'h0, i, 2'h0};
		m.rready <= (lag == 0);
		do begin
			@(posedge aclk);
			if (s.arready)
				m.arvalid <= 1'b0;
		end while (!s.rvalid);
		if (lag > 0) begin
			repeat (lag) @(posedge aclk);
			m.rready <= 1'b1;
			@(posedge aclk);
		end
		d = s.rdata;
		r = s.rresp;
		m.rready <= 1'b0;
	endtask : rd
	task automatic rdc(input logic [15:0] i, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0] r;
		rd(i, d, r);
		`CHK(nm, e, d)
	endtask : rdc
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rdc(TPL_IDX_STATUS, 32'h0, "status");
		// Late takers leave the answers standing for a while
		lag = 2;
		wr(TPL_IDX_ONE_RISE, 32'h1234_5678);
		`CHK("ro bresp", TPL_RESP_OKAY, last_bresp);
		rdc(TPL_IDX_ONE_RISE, 32'h0, "rise1 ro");
		lag = 0;
		rd(16'h0, d, r);
		`CHK("bad resp", TPL_RESP_SLVERR, r);
		`CHK("bad data", 32'h0, d);
		wr(16'h0, 32'h0);
		`CHK("bad bresp", TPL_RESP_SLVERR, last_bresp);
		$display("test reset done");
	endtask : t_reset
	task automatic t_single;
		wr(TPL_IDX_CTRL, 32'h31);
		u_pm.pulse(0, 32'h1111, 32'hffff_f000, 12);
		rdc(TPL_IDX_STATUS, 32'h07, "status");
		rdc(TPL_IDX_ONE_RISE, 32'h1111, "rise1");
		rdc(TPL_IDX_ONE_FALL, 32'hffff_f000, "fall1");
		u_pm.pulse(0, 32'h2222, 32'h3333, 12);
		rdc(TPL_IDX_ONE_RISE, 32'h1111, "rise1 kept");
		rdc(TPL_IDX_ONE_FALL, 32'hffff_f000, "fall1 kept");
		wr(TPL_IDX_CTRL, 32'h0);
		rdc(TPL_IDX_STATUS, 32'h0, "status off");
		$display("test single done");
	endtask : t_single
	task automatic t_cont;
		wr(TPL_IDX_CTRL, 32'h3317);
		for (int k = 1; k <= 4; k++) begin
			u_pm.pulse(1, 32'(k), -32'(k), 12);
			u_pm.pulse(3, 32'(k * 16), 32'h0, 12);
			rdc(TPL_IDX_STATUS, 32'h0703 | (32'(2 * k % 4) << 14) | (32'(k % 4) << 6),
				"status");
			rdc(TPL_IDX_TWO_RISE, 32'(k), "rise2");
			rdc(TPL_IDX_TWO_FALL, -32'(k), "fall2");
			rdc(TPL_IDX_ONE_RISE, 32'(k * 16), "enc rise1");
		end
		wr(TPL_IDX_CTRL, 32'h0);
		$display("test continuous done");
	endtask : t_cont
	task automatic t_filt;
		wr(TPL_IDX_FILT, 32'd100);
		wr(TPL_IDX_CTRL, 32'h11);
		u_pm.pulse(0, 32'h5, 32'h6, 20);
		rdc(TPL_IDX_STATUS, 32'h01, "short pulse");
		u_pm.pulse(0, 32'h7, 32'h8, 60);
		rdc(TPL_IDX_STATUS, 32'h03, "long pulse");
		rdc(TPL_IDX_ONE_RISE, 32'h7, "filt rise1");
		wr(TPL_IDX_FILT, 32'd0);
		wr(TPL_IDX_CTRL, 32'h0);
		$display("test filter done");
	endtask : t_filt
	task automatic t_sel;
		wr(TPL_IDX_PIN_SEL, 32'h6);
		wr(TPL_IDX_POL, 32'h3);
		wr(TPL_IDX_RESTART, 32'h1);
		u_pm.set_idle(3'h1);
		repeat (8) @(posedge aclk);
		wr(TPL_IDX_CTRL, 32'h1111);
		u_pm.pulse(0, 32'h9, 32'ha, 12);
		rdc(TPL_IDX_STATUS, 32'h0101, "old pin");
		u_pm.pulse(2, 32'hb, 32'hc, 12);
		rdc(TPL_IDX_STATUS, 32'h0103, "new pin");
		rdc(TPL_IDX_ONE_RISE, 32'hb, "pol rise1");
		u_pm.pulse(1, 32'hd, 32'he, 12);
		rdc(TPL_IDX_STATUS, 32'h0303, "pol two");
		rdc(TPL_IDX_TWO_RISE, 32'hd, "pol rise2");
		$display("test select done");
	endtask : t_sel
	// ==========================================================
	// Verdict
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// Run takes some 700 cycles; the limit leaves wide room
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_single();
		t_cont();
		t_filt();
		t_sel();
		report_and_stop();
	end
endmodule : test_touch_probe_position_latch
